// file: rtl/synth_cal_and_freq_words.sv
// Serial program port and decoder of the calibration and frequency words.
// Summary of operation
// - Selector 01 routes the word to the calibration control register.
// - Calibration word: bits 19:2 control field, bit 20 enable, 25:21 reserved.
// - Selector 10 routes the word to the first frequency control register.
// - Bits 3:2 choose reference divide: 00 eight, 01 four, 10 two, 11 one.
// - Bits 15:10 load coarse counter; bits 9:6 load extra-cycle counter.
// - In divide-by-16/17 mode all four extra-cycle bits are used.
// - In divide-by-8/9 mode only three extra-cycle bits; bit 9 ignored.
// - Bit 17 zero holds modulator in reset; one lets it run.
// - Bit 18 zero selects integer mode; one selects fractional mode.
// - Frequency word bits 23:20 give modulus extension bits 3:0.
// - Selector 11 word bits 12:2 give modulus extension bits 14:4.
// - Mode word bit 23 selects 8/9 when zero, 16/17 when one.
`timescale 1ns/10ps
`include "synth_params.svh"
module synth_cal_and_freq_words
  import synth_pkg::*;
(
  input  wire logic  ref_clk,
  input  wire logic  rstn,
  input  wire logic  ser_clk,
  input  wire logic  ser_data,
  input  wire logic  ser_load,
  output cal_cfg_t   cal_cfg,
  output freq_cfg_t  freq_cfg,
  output logic [9:0] feedback_count,
  output logic       word_loaded,
  output logic       word_dropped
);

  logic                  clk_s;
  logic                  data_s;
  logic                  load_s;
  logic                  clk_d_reg;
  logic                  load_d_reg;
  logic                  clk_rise;
  logic                  load_rise;
  logic [`WORD_W-1:0]    shift_reg;
  logic [`BITCNT_W-1:0]  bitcnt_reg;
  logic [`WORD_W-1:0]    word_reg;
  load_state_t           state_reg;
  load_state_t           state_next;
  word_sel_t             sel;
  logic                  commit;

  logic [17:0]           cal_ctrl_reg;
  logic                  cal_en_reg;
  logic [1:0]            rdiv_reg;
  logic [5:0]            m_reg;
  logic [3:0]            a_reg;
  logic                  mod_run_reg;
  logic                  frac_sel_reg;
  logic [3:0]            mext_lo_reg;
  logic [10:0]           mext_hi_reg;
  logic                  prescale_reg;
  logic [3:0]            ratio_next;
  logic [3:0]            ratio_reg;
  logic                  prescale_next;
  logic [3:0]            a_used_next;
  logic [3:0]            a_used_reg;

  // The serial pins come from the host's domain, so each is synchronised.
  bit_sync #(.RESET_VAL(1'b0)) u_sync_clk (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .din     (ser_clk),
    .dout    (clk_s)
  );

  bit_sync #(.RESET_VAL(1'b0)) u_sync_data (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .din     (ser_data),
    .dout    (data_s)
  );

  bit_sync #(.RESET_VAL(1'b1)) u_sync_load (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .din     (ser_load),
    .dout    (load_s)
  );

  // Edges are taken from the second stage only.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      clk_d_reg  <= 1'b0;
      load_d_reg <= 1'b1;
    end else begin
      clk_d_reg  <= clk_s;
      load_d_reg <= load_s;
    end
  end

  assign clk_rise  = clk_s & ~clk_d_reg;
  assign load_rise = load_s & ~load_d_reg;

  // Shifting happens only while the load line is low, MSB first.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      shift_reg <= '0;
    end else if (clk_rise && !load_s) begin
      shift_reg <= {shift_reg[`WORD_W-2:0], data_s};
    end
  end

  // The bit counter saturates so that an overlong frame is not mistaken
  // for a full one after wrapping.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bitcnt_reg <= '0;
    end else if (load_rise) begin
      bitcnt_reg <= '0;
    end else if (clk_rise && !load_s && bitcnt_reg != `BITCNT_MAX) begin
      bitcnt_reg <= bitcnt_reg + 1'b1;
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (!load_s) begin
          state_next = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (load_rise) begin
          state_next = (bitcnt_reg == `BITCNT_FULL) ? ST_COMMIT : ST_IDLE;
        end
      end
      ST_COMMIT: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // The completed word is frozen here so later shifting cannot disturb it.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      word_reg <= '0;
    end else if (state_reg == ST_SHIFT && load_rise &&
                 bitcnt_reg == `BITCNT_FULL) begin
      word_reg <= shift_reg;
    end
  end

  // The commit state lasts one cycle, so each target is written once.
  assign commit = (state_reg == ST_COMMIT);
  assign sel    = word_sel_t'(word_reg[`SEL_MSB:`SEL_LSB]);

  // Status pulses for the surrounding logic; a refused frame touches no
  // register and shows only as a drop pulse.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      word_loaded  <= 1'b0;
      word_dropped <= 1'b0;
    end else begin
      word_loaded  <= commit;
      word_dropped <= (state_reg == ST_SHIFT) && load_rise &&
                      (bitcnt_reg != `BITCNT_FULL);
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cal_ctrl_reg <= `RST_CAL_CTRL;
      cal_en_reg   <= `RST_CAL_EN;
    end else if (commit && sel == WSEL_CAL) begin
      cal_ctrl_reg <= word_reg[`CAL_CTRL_MSB:`CAL_CTRL_LSB];
      cal_en_reg   <= word_reg[`CAL_EN_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdiv_reg     <= `RST_RDIV;
      m_reg        <= `RST_M;
      a_reg        <= `RST_A;
      mod_run_reg  <= `RST_MOD_RUN;
      frac_sel_reg <= `RST_FRAC_SEL;
      mext_lo_reg  <= `RST_MEXT_LO;
    end else if (commit && sel == WSEL_FREQ1) begin
      rdiv_reg     <= word_reg[`RDIV_MSB:`RDIV_LSB];
      m_reg        <= word_reg[`M_MSB:`M_LSB];
      a_reg        <= word_reg[`A_MSB:`A_LSB];
      mod_run_reg  <= word_reg[`MOD_RUN_BIT];
      frac_sel_reg <= word_reg[`FRAC_SEL_BIT];
      mext_lo_reg  <= word_reg[`MEXT_LO_MSB:`MEXT_LO_LSB];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mext_hi_reg <= `RST_MEXT_HI;
    end else if (commit && sel == WSEL_FREQ2) begin
      mext_hi_reg <= word_reg[`MEXT_HI_MSB:`MEXT_HI_LSB];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      prescale_reg <= `RST_PRESCALE;
    end else if (commit && sel == WSEL_MODE) begin
      prescale_reg <= word_reg[`PRESCALE_BIT];
    end
  end

  // reference ratio map
  // The ratio is decoded from the frozen word and registered beside the
  // code, so the whole frequency word lands on one edge.
  always_comb begin
    if (word_reg[`RDIV_MSB:`RDIV_LSB] == `RDIV_CODE_DIV8) begin
      ratio_next = `RATIO_8;
    end else if (word_reg[`RDIV_MSB:`RDIV_LSB] == `RDIV_CODE_DIV4) begin
      ratio_next = `RATIO_4;
    end else if (word_reg[`RDIV_MSB:`RDIV_LSB] == `RDIV_CODE_DIV2) begin
      ratio_next = `RATIO_2;
    end else begin
      ratio_next = `RATIO_1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ratio_reg <= `RATIO_8;
    end else if (commit && sel == WSEL_FREQ1) begin
      ratio_reg <= ratio_next;
    end
  end

  // top bit dropped in 8/9
  // The raw count stays in a_reg, so a later switch to 16/17 brings the
  // top bit back without the frequency word being sent again.
  always_comb begin
    prescale_next = prescale_reg;
    a_used_next   = a_reg;
    if (commit && sel == WSEL_MODE) begin
      prescale_next = word_reg[`PRESCALE_BIT];
    end
    if (commit && sel == WSEL_FREQ1) begin
      a_used_next = word_reg[`A_MSB:`A_LSB];
    end
    if (!prescale_next) begin
      a_used_next[`A_TOP] = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      a_used_reg <= `RST_A;
    end else begin
      a_used_reg <= a_used_next;
    end
  end

  // Outputs are assembled from registers; the extension halves may be
  // written in either order and only match once both words have landed.
  always_comb begin
    cal_cfg.ctrl   = cal_ctrl_reg;
    cal_cfg.enable = cal_en_reg;
    freq_cfg.rdiv_code   = rdiv_reg;
    freq_cfg.ref_ratio   = ratio_reg;
    freq_cfg.m_count     = m_reg;
    freq_cfg.a_count     = a_used_reg;
    freq_cfg.mod_run     = mod_run_reg;
    freq_cfg.frac_mode   = frac_sel_reg;
    freq_cfg.modulus_extension = {mext_hi_reg, mext_lo_reg};
    freq_cfg.prescale_16 = prescale_reg;
    feedback_count = {m_reg, a_used_reg};
  end

endmodule

// file: rtl/synth_params.svh
// Field positions, divider codes and reset values of the program words.
`ifndef SYNTH_PARAMS_SVH
`define SYNTH_PARAMS_SVH

`define WORD_W          26
`define BITCNT_W        5
`define BITCNT_FULL     5'h1A
`define BITCNT_MAX      5'h1F

`define SEL_MSB         1
`define SEL_LSB         0

`define CAL_CTRL_MSB    19
`define CAL_CTRL_LSB    2
`define CAL_EN_BIT      20

`define RDIV_MSB        3
`define RDIV_LSB        2
`define M_MSB           15
`define M_LSB           10
`define A_MSB           9
`define A_LSB           6
`define A_TOP           3
`define MOD_RUN_BIT     17
`define FRAC_SEL_BIT    18
`define MEXT_LO_MSB     23
`define MEXT_LO_LSB     20
`define MEXT_HI_MSB     12
`define MEXT_HI_LSB     2
`define PRESCALE_BIT    23

`define RDIV_CODE_DIV8  2'h0
`define RDIV_CODE_DIV4  2'h1
`define RDIV_CODE_DIV2  2'h2
`define RDIV_CODE_DIV1  2'h3
`define RATIO_8         4'h8
`define RATIO_4         4'h4
`define RATIO_2         4'h2
`define RATIO_1         4'h1

`define RST_CAL_CTRL    18'h00000
`define RST_CAL_EN      1'h0
`define RST_RDIV        2'h0
`define RST_M           6'h00
`define RST_A           4'h0
`define RST_MOD_RUN     1'h0
`define RST_FRAC_SEL    1'h0
`define RST_MEXT_LO     4'h0
`define RST_MEXT_HI     11'h000
`define RST_PRESCALE    1'h0

`endif

// file: rtl/synth_pkg.sv
// Types shared by the program word decoder.
package synth_pkg;

  typedef enum logic [1:0] {
    WSEL_MODE  = 2'b00,
    WSEL_CAL   = 2'b01,
    WSEL_FREQ1 = 2'b10,
    WSEL_FREQ2 = 2'b11
  } word_sel_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SHIFT  = 2'b01,
    ST_COMMIT = 2'b10
  } load_state_t;

  typedef struct packed {
    logic [17:0] ctrl;
    logic        enable;
  } cal_cfg_t;

  typedef struct packed {
    logic [1:0]  rdiv_code;
    logic [3:0]  ref_ratio;
    logic [5:0]  m_count;
    logic [3:0]  a_count;
    logic        mod_run;
    logic        frac_mode;
    logic [14:0] modulus_extension;
    logic        prescale_16;
  } freq_cfg_t;

endpackage

// file: rtl/bit_sync.sv
// Two-flop synchroniser for one pin input.
`timescale 1ns/10ps
module bit_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic din,
  output logic      dout
);

  logic meta_reg;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= RESET_VAL;
      dout     <= RESET_VAL;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end

endmodule

// file: bench/synth_cal_and_freq_words_chk.sv
// Port checker for the program word decoder.
`timescale 1ns/10ps
module synth_cal_and_freq_words_chk
  import synth_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rstn,
  input wire logic       ser_clk,
  input wire logic       ser_data,
  input wire logic       ser_load,
  input wire cal_cfg_t   cal_cfg,
  input wire freq_cfg_t  freq_cfg,
  input wire logic [9:0] feedback_count,
  input wire logic       word_loaded,
  input wire logic       word_dropped
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_end;
    $rose(ser_load);
  endsequence
  // Drop replies come 3 cycles and load replies 4 cycles after the strobe; the window allows up to 7.
  sequence s_reply;
    ##[3:7] (word_loaded || word_dropped);
  endsequence
  chk_ratio_map:
    assert property (freq_cfg.ref_ratio == (4'h8 >> freq_cfg.rdiv_code))
    else $error("ref_ratio does not match rdiv_code");
  chk_fb_join:
    assert property (feedback_count == {freq_cfg.m_count, freq_cfg.a_count})
    else $error("feedback_count does not join m and a");
  chk_a_mask:
    assert property (!freq_cfg.prescale_16 |-> !freq_cfg.a_count[3])
    else $error("a_count bit 3 used in 8/9 mode");
  chk_load_pulse:
    assert property (word_loaded |=> !word_loaded)
    else $error("word_loaded longer than one cycle");
  chk_word_reply:
    assert property (s_end |-> s_reply)
    else $error("no load or drop answer after load strobe");
  chk_cal_hold:
    assert property ($changed(cal_cfg) |-> word_loaded)
    else $error("cal_cfg changed without a committed word");
  chk_freq_hold:
    assert property ($changed(freq_cfg) |-> word_loaded)
    else $error("freq_cfg changed without a committed word");
  chk_drop_keep:
    assert property (word_dropped |-> $stable(cal_cfg) && $stable(freq_cfg))
    else $error("registers changed on a dropped word");
endmodule

bind synth_cal_and_freq_words synth_cal_and_freq_words_chk u_chk (
  .ref_clk, .rstn, .ser_clk, .ser_data, .ser_load, .cal_cfg, .freq_cfg,
  .feedback_count, .word_loaded, .word_dropped);

// file: bench/serial_host.sv
// Host model that shifts program words into the serial port.
`timescale 1ns/10ps
module serial_host (
  input  wire logic ref_clk,
  output logic      ser_clk,
  output logic      ser_data,
  output logic      ser_load
);
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_load = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Sends n bits top first; a count other than 26 makes a refused frame.
  task automatic send(input logic [25:0] w, input int n);
    ser_load = 1'b0;
    tick(6);
    for (int i = 0; i < n; i++) begin
      ser_data = (i < 26) ? w[25 - i] : 1'b0;
      tick(3);
      ser_clk = 1'b1;
      tick(3);
      ser_clk = 1'b0;
    end
    tick(3);
    // A released data line must not keep showing the last bit.
    ser_data = ~ser_data;
    ser_load = 1'b1;
    tick(12);
  endtask
endmodule

// file: bench/synth_cal_and_freq_words_test.sv
// Self-checking bench for the program word decoder.
`timescale 1ns/10ps
module synth_cal_and_freq_words_test
  import synth_pkg::*;
;
  logic       ref_clk;
  logic       rstn;
  logic       ser_clk;
  logic       ser_data;
  logic       ser_load;
  cal_cfg_t   cal_cfg;
  freq_cfg_t  freq_cfg;
  logic [9:0] feedback_count;
  logic       word_loaded;
  logic       word_dropped;
  int         err_count;
  int         cmp_count;
  int         n_load = 0;
  int         n_drop = 0;

  serial_host host (.ref_clk, .ser_clk, .ser_data, .ser_load);
  synth_cal_and_freq_words dut (.ref_clk, .rstn, .ser_clk, .ser_data,
    .ser_load, .cal_cfg, .freq_cfg, .feedback_count, .word_loaded,
    .word_dropped);

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (word_loaded === 1'b1) n_load <= n_load + 1;
    if (word_dropped === 1'b1) n_drop <= n_drop + 1;
  end

  task automatic check(input string what, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // selector 10, bit 19 set, reserved zero.
  function automatic logic [25:0] fw1(input logic [1:0] r, mf);
    return {2'h0, 4'hA, 1'b1, mf, 1'b0, 6'h2D, 4'hB, 2'h0, r, 2'h2};
  endfunction
  // mode word with only the prescaler bit set.
  function automatic logic [25:0] mw(input logic p);
    return {2'h0, p, 23'h0};
  endfunction

  task automatic t_reset();
    check("ratio", freq_cfg.ref_ratio, 4'h8);
    check("cal", cal_cfg, 19'h0);
    $display("test reset done");
  endtask

  task automatic t_cal();
    int l;
    l = n_load;
    host.send({5'h0, 1'b1, 18'h2AAAA, 2'h1}, 26);
    check("cal_ctrl", cal_cfg.ctrl, 18'h2AAAA);
    check("cal_en", cal_cfg.enable, 1'b1);
    host.send({5'h0, 1'b0, 18'h15555, 2'h1}, 26);
    check("cal_word", cal_cfg, {18'h15555, 1'b0});
    check("loads", n_load - l, 2);
    $display("test cal done");
  endtask

  task automatic t_freq();
    host.send(mw(1'b1), 26);
    check("pre16", freq_cfg.prescale_16, 1'b1);
    for (int r = 0; r < 4; r++) begin
      host.send(fw1(r[1:0], r[1:0]), 26);
      check("code", freq_cfg.rdiv_code, r);
      check("ratio", freq_cfg.ref_ratio, 4'h8 >> r);
      check("run", freq_cfg.mod_run, r[0]);
      check("frac", freq_cfg.frac_mode, r[1]);
    end
    check("m", freq_cfg.m_count, 6'h2D);
    check("a16", freq_cfg.a_count, 4'hB);
    check("ext_lo", freq_cfg.modulus_extension, 15'hA);
    host.send(mw(1'b0), 26);
    check("pre89", freq_cfg.prescale_16, 1'b0);
    check("a89", freq_cfg.a_count, 4'h3);
    check("fb", feedback_count, {6'h2D, 4'h3});
    host.send({13'h0, 11'h5A5, 2'h3}, 26);
    check("ext", freq_cfg.modulus_extension, {11'h5A5, 4'hA});
    $display("test freq done");
  endtask

  task automatic t_part();
    int l;
    int d;
    l = n_load;
    d = n_drop;
    host.send({5'h0, 1'b1, 18'h3FFFF, 2'h1}, 25);
    host.send({5'h0, 1'b1, 18'h3FFFF, 2'h1}, 27);
    check("cal_kept", cal_cfg, {18'h15555, 1'b0});
    check("drops", n_drop - d, 2);
    check("loads", n_load - l, 0);
    $display("test partial done");
  endtask

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    err_count = 0;
    cmp_count = 0;
    rstn = 1'b0;
    repeat (2) @(negedge ref_clk);
    rstn = 1'b1;
    @(negedge ref_clk);
    t_reset();
    t_cal();
    t_freq();
    t_part();
    end_of_test();
  end
  initial begin
    #100000;
    err_count++;
    $display("Error run expected finish seen timeout");
    end_of_test();
  end
endmodule
